// ===== core/stack_psw_control.sv
// Behaviour
// - register push writes upper and lower nibble, pointer drops by two
// - call saves counter and both bank flags in six nibbles
// - interrupt entry saves counter and whole status word, pointer drops six
// - pop restores lower nibble first then upper, pointer rises two
// - subroutine exit reloads counter and bank flags, pointer rises six
// - interrupt exit reloads counter and status word, pointer rises six
// - stack pointer bit 0 always reads and stays zero
// - sixteen-bit bit carrier, bit nibble byte access, clears on reset
// - byte access reaches carrier as nibble0 pair and nibble2 pair
// - indexed bit uses L upper bits as nibble, lower bits as bit
// - indexed carrier bit access ignores memory bank enable flag
// - fourteen-bit counter clears to zero on reset, loads vector address on interrupt
// - counter advances by instruction length except the rom reference op
// - status word high nibble level bits and bank flags, low carry and skips
// - status word reachable at fixed address regardless of bank flag
// - level bits 1/4-bit, flags 1-bit, skip bits readable by byte only
// - reset clears bank flags, level and skip bits
// - interrupt entry pushes level then raises level 0 or 1 one step; exit restores
// - level 0 admits all, 1 high priority only, 2 none
// - eight-bit pointer over two nibble locations, low bit zero
// - stack accesses always in bank 0, addresses 000H-0FFH
// - register bank flag loads from vector bit 6 on interrupt, clears on reset
`timescale 1ns/100ps
module stack_psw_control #(
  parameter int PC_W = 14
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // stack command from the instruction sequencer
  input wire logic i_cmd_valid,
  input wire stack_psw_pkg::stack_cmd_type i_cmd,
  input wire logic [7:0] i_push_data,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_pop_data,
  // counter control
  input wire logic i_pc_advance,
  input wire logic [1:0] i_instr_len,
  input wire logic i_rom_ref,
  input wire logic [PC_W-1:0] i_rom_ref_target,
  input wire logic i_jump,
  input wire logic [PC_W-1:0] i_jump_target,
  input wire logic [PC_W-1:0] i_vector_addr,
  input wire logic [7:0] i_vector_byte,
  output logic [PC_W-1:0] o_prog_counter,
  // data memory path for stack nibbles
  output logic o_mem_we,
  output logic o_mem_re,
  output logic [11:0] o_mem_addr,
  output logic [3:0] o_mem_wdata,
  input wire logic [3:0] i_mem_rdata,
  // register access at fixed addresses
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [1:0] i_reg_width,
  input wire logic [11:0] i_reg_addr,
  input wire logic [1:0] i_reg_bit,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // indexed carrier bit access
  input wire logic i_idx_wr,
  input wire logic [3:0] i_idx_l,
  input wire logic i_idx_wbit,
  output logic o_idx_rbit,
  // core status
  input wire logic i_carry_set,
  input wire logic i_carry_in,
  input wire logic [2:0] i_skip_in,
  input wire logic i_skip_load,
  input wire logic i_irq_high_prio,
  output logic o_irq_admit,
  output logic [1:0] o_irq_level,
  output logic o_mem_bank_enable_flag,
  output logic o_reg_bank_enable_flag,
  output logic o_carry,
  output logic [7:0] o_stack_ptr,
  output logic [15:0] o_bit_seq_carrier
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} seq_state_type;

  seq_state_type state_q, state_d;
  stack_psw_pkg::stack_cmd_type cmd_q, cmd_d;
  logic [2:0] step_q, step_d;
  logic [7:0] sp_q, sp_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [15:0] carrier_q, carrier_d;
  logic [1:0] level_q, level_d;
  logic mbank_q, mbank_d, rbank_q, rbank_d, carry_q, carry_d;
  logic [2:0] skip_q, skip_d;
  logic [7:0] pdata_q, pdata_d;
  logic [23:0] frame_q, frame_d;
  logic done_q, done_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] last_step;

  function automatic logic [7:0] frame_len(input stack_psw_pkg::stack_cmd_type c);
    frame_len = (c == stack_psw_pkg::CMD_PUSH || c == stack_psw_pkg::CMD_POP)
      ? stack_psw_pkg::FRAME_PAIR : stack_psw_pkg::FRAME_CALL;
  endfunction : frame_len

  function automatic logic is_pop(input stack_psw_pkg::stack_cmd_type c);
    is_pop = (c == stack_psw_pkg::CMD_POP) || (c == stack_psw_pkg::CMD_RET) ||
      (c == stack_psw_pkg::CMD_INTERRUPT_EXIT);
  endfunction : is_pop

  // frame nibble k of a 24-bit frame, nibble 0 lowest
  function automatic logic [3:0] nib(input logic [23:0] f, input logic [2:0] k);
    nib = f[{k, 2'b00} +: 4];
  endfunction : nib

  assign last_step = 3'(frame_len(cmd_q) - 8'h01);

  // stack sequencer: one nibble per cycle, bank 0 only
  always_comb begin
    logic [23:0] fr;
    logic [7:0] a;
    fr = '0;
    a = '0;
    state_d = state_q;
    cmd_d = cmd_q;
    step_d = step_q;
    frame_d = frame_q;
    done_d = 1'b0;
    o_mem_we = 1'b0;
    o_mem_re = 1'b0;
    o_mem_addr = 12'h000;
    o_mem_wdata = 4'h0;
    case (state_q)
      ST_IDLE: begin
        if (i_cmd_valid && i_cmd != stack_psw_pkg::CMD_NONE) begin
          cmd_d = i_cmd;
          step_d = 3'h0;
          state_d = ST_RUN;
          fr[7:0] = i_push_data;
          if (i_cmd == stack_psw_pkg::CMD_CALL) begin
            // same nibble layout as interrupt entry so both exits decode alike
            fr = {8'(pc_q), 2'b00, mbank_q, rbank_q, 4'h0, 2'b00, pc_q[PC_W-1:8]};
          end else if (i_cmd == stack_psw_pkg::CMD_IRQ) begin
            fr = {8'(pc_q), level_q, mbank_q, rbank_q, carry_q, skip_q,
              2'b00, pc_q[PC_W-1:8]};
          end
          frame_d = fr;
        end
      end
      ST_RUN: begin
        // pushes fill downward from sp-1, pops read upward from sp
        a = is_pop(cmd_q) ? 8'(sp_q + 8'(step_q)) : 8'(sp_q - 8'(step_q) - 8'h01);
        o_mem_addr = {4'h0, a};
        if (is_pop(cmd_q)) begin
          o_mem_re = 1'b1;
          frame_d[{step_q, 2'b00} +: 4] = i_mem_rdata;
        end else begin
          o_mem_we = 1'b1;
          o_mem_wdata = nib(frame_q, 3'(3'h5 - step_q));
          if (cmd_q == stack_psw_pkg::CMD_PUSH) begin
            o_mem_wdata = nib(frame_q, 3'(3'h1 - step_q));
          end
        end
        step_d = 3'(step_q + 3'h1);
        if (step_q == last_step) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // architectural state: pointer, counter, status word, carrier
  always_comb begin
    logic [23:0] f;
    logic [3:0] wn;
    f = frame_q;
    wn = 4'h0;
    sp_d = sp_q;
    pc_d = pc_q;
    carrier_d = carrier_q;
    level_d = level_q;
    mbank_d = mbank_q;
    rbank_d = rbank_q;
    carry_d = carry_q;
    skip_d = skip_q;
    pdata_d = pdata_q;
    rdata_d = rdata_q;
    if (i_pc_advance) begin
      // rom reference jumps to its table entry instead of advancing
      pc_d = i_rom_ref ? i_rom_ref_target : PC_W'(pc_q + PC_W'(i_instr_len));
    end
    if (i_jump) begin
      pc_d = i_jump_target;
    end
    if (i_carry_set) begin
      carry_d = i_carry_in;
    end
    if (i_skip_load) begin
      skip_d = i_skip_in;
    end
    // indexed bit access, independent of bank flag
    if (i_idx_wr) begin
      carrier_d[i_idx_l] = i_idx_wbit;
    end
    if (i_reg_rd) begin
      rdata_d = 8'h00;
      case (i_reg_addr)
        stack_psw_pkg::ADDR_STATUS_HI:
          rdata_d = (i_reg_width == stack_psw_pkg::ACC_BYTE)
            ? {carry_q, skip_q, level_q, mbank_q, rbank_q}
            : {4'h0, level_q, mbank_q, rbank_q};
        // skip bits stay hidden outside byte reads
        stack_psw_pkg::ADDR_STATUS_LO: rdata_d = {4'h0, carry_q, 3'h0};
        stack_psw_pkg::ADDR_CARRIER0: rdata_d = (i_reg_width == stack_psw_pkg::ACC_BYTE)
          ? carrier_q[7:0] : {4'h0, carrier_q[3:0]};
        stack_psw_pkg::ADDR_CARRIER1: rdata_d = {4'h0, carrier_q[7:4]};
        stack_psw_pkg::ADDR_CARRIER2: rdata_d = (i_reg_width == stack_psw_pkg::ACC_BYTE)
          ? carrier_q[15:8] : {4'h0, carrier_q[11:8]};
        stack_psw_pkg::ADDR_CARRIER3: rdata_d = {4'h0, carrier_q[15:12]};
        stack_psw_pkg::ADDR_SP_LO: rdata_d = (i_reg_width == stack_psw_pkg::ACC_BYTE)
          ? sp_q : {4'h0, sp_q[3:0]};
        stack_psw_pkg::ADDR_SP_HI: rdata_d = {4'h0, sp_q[7:4]};
        default: rdata_d = 8'h00;
      endcase
      // a 1-bit read returns the addressed bit in bit 0
      if (i_reg_width == stack_psw_pkg::ACC_BIT) begin
        rdata_d = {7'h00, rdata_d[i_reg_bit]};
      end
    end
    if (i_reg_wr) begin
      // a 1-bit write merges into a status or carrier nibble; pointer nibbles take the whole written nibble
      wn = i_reg_wdata[3:0];
      case (i_reg_addr)
        stack_psw_pkg::ADDR_STATUS_HI: begin
          wn = {level_q, mbank_q, rbank_q};
          if (i_reg_width == stack_psw_pkg::ACC_BIT) begin
            wn[i_reg_bit] = i_reg_wdata[0];
          end else if (i_reg_width == stack_psw_pkg::ACC_NIB) begin
            wn[3:2] = i_reg_wdata[3:2];
          end
          level_d = wn[3:2];
          mbank_d = wn[stack_psw_pkg::POS_MEM_BANK];
          rbank_d = wn[stack_psw_pkg::POS_REG_BANK];
        end
        stack_psw_pkg::ADDR_STATUS_LO: begin
          if (i_reg_width == stack_psw_pkg::ACC_BIT &&
              i_reg_bit == 2'(stack_psw_pkg::POS_CARRY)) begin
            carry_d = i_reg_wdata[0];
          end
        end
        stack_psw_pkg::ADDR_CARRIER0, stack_psw_pkg::ADDR_CARRIER1,
        stack_psw_pkg::ADDR_CARRIER2, stack_psw_pkg::ADDR_CARRIER3: begin
          if (i_reg_width == stack_psw_pkg::ACC_BIT) begin
            carrier_d[{i_reg_addr[1:0], i_reg_bit}] = i_reg_wdata[0];
          end else if (i_reg_width == stack_psw_pkg::ACC_BYTE) begin
            carrier_d[{i_reg_addr[1], 3'b000} +: 8] = i_reg_wdata;
          end else begin
            carrier_d[{i_reg_addr[1:0], 2'b00} +: 4] = i_reg_wdata[3:0];
          end
        end
        stack_psw_pkg::ADDR_SP_LO: begin
          if (i_reg_width == stack_psw_pkg::ACC_BYTE) begin
            sp_d = {i_reg_wdata[7:1], 1'b0};
          end else begin
            sp_d[3:0] = {i_reg_wdata[3:1], 1'b0};
          end
        end
        stack_psw_pkg::ADDR_SP_HI: sp_d[7:4] = i_reg_wdata[3:0];
        default: ;
      endcase
    end
    // frame completion
    if (state_q == ST_RUN && step_q == last_step) begin
      if (is_pop(cmd_q)) begin
        f[{step_q, 2'b00} +: 4] = i_mem_rdata;
        sp_d = 8'(sp_q + frame_len(cmd_q));
        case (cmd_q)
          // lower nibble came first, so it sits in f[3:0]
          stack_psw_pkg::CMD_POP: pdata_d = {f[7:4], f[3:0]};
          stack_psw_pkg::CMD_RET: begin
            pc_d = PC_W'({f[5:4], f[3:0], f[23:16]});
            mbank_d = f[13];
            rbank_d = f[12];
          end
          stack_psw_pkg::CMD_INTERRUPT_EXIT: begin
            pc_d = PC_W'({f[5:4], f[3:0], f[23:16]});
            {level_d, mbank_d, rbank_d} = f[15:12];
            carry_d = f[11];
            skip_d = f[10:8];
          end
          default: ;
        endcase
      end else begin
        sp_d = 8'(sp_q - frame_len(cmd_q));
        if (cmd_q == stack_psw_pkg::CMD_IRQ) begin
          pc_d = i_vector_addr;
          mbank_d = i_vector_byte[stack_psw_pkg::POS_VEC_MEM_BANK];
          rbank_d = i_vector_byte[stack_psw_pkg::POS_VEC_REG_BANK];
          level_d = (level_q == stack_psw_pkg::LEVEL_NONE) ? level_q
            : 2'(level_q + 2'h1);
        end
      end
    end
    sp_d[0] = 1'b0;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cmd_q <= stack_psw_pkg::CMD_NONE;
      step_q <= 3'h0;
      frame_q <= 24'h000000;
      done_q <= 1'b0;
      sp_q <= stack_psw_pkg::RST_SP;
      carrier_q <= stack_psw_pkg::RST_CARRIER;
      level_q <= stack_psw_pkg::RST_LEVEL;
      skip_q <= stack_psw_pkg::RST_SKIP;
      pdata_q <= 8'h00;
      rdata_q <= 8'h00;
      pc_q <= '0;
      mbank_q <= 1'b0;
      rbank_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      step_q <= step_d;
      frame_q <= frame_d;
      done_q <= done_d;
      sp_q <= sp_d;
      carrier_q <= carrier_d;
      level_q <= level_d;
      skip_q <= skip_d;
      pdata_q <= pdata_d;
      rdata_q <= rdata_d;
      pc_q <= pc_d;
      mbank_q <= mbank_d;
      rbank_q <= rbank_d;
    end
  end

  // carry has no reset: it keeps its value through a reset
  always_ff @(posedge i_clk_sys) begin
    carry_q <= carry_d;
  end

  assign o_busy = (state_q != ST_IDLE);
  assign o_done = done_q;
  assign o_pop_data = pdata_q;
  assign o_prog_counter = pc_q;
  assign o_reg_rdata = rdata_q;
  assign o_idx_rbit = carrier_q[i_idx_l];
  assign o_irq_level = level_q;
  // level 3 is undefined and admits nothing
  assign o_irq_admit = (level_q == stack_psw_pkg::LEVEL_ALL) ||
    (level_q == stack_psw_pkg::LEVEL_HIGH && i_irq_high_prio);
  assign o_mem_bank_enable_flag = mbank_q;
  assign o_reg_bank_enable_flag = rbank_q;
  assign o_carry = carry_q;
  assign o_stack_ptr = sp_q;
  assign o_bit_seq_carrier = carrier_q;

  property p_sp_even;
    @(posedge i_clk_sys) disable iff (i_rst) sp_q[0] == 1'b0;
  endproperty
  a_sp_even: assert property (p_sp_even) else $error("stack pointer odd");

  property p_irq_sp;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == ST_RUN && cmd_q == stack_psw_pkg::CMD_IRQ && step_q == last_step
       && !i_reg_wr) |=> sp_q == 8'($past(sp_q) - 8'h06);
  endproperty
  a_irq_sp: assert property (p_irq_sp) else $error("irq frame not six");

  property p_push_sp;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == ST_IDLE && i_cmd_valid && i_cmd == stack_psw_pkg::CMD_PUSH && !i_reg_wr)
      |=> ##2 sp_q == 8'($past(sp_q, 3) - 8'h02);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push not two");

  property p_bank0;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_mem_we || o_mem_re) |-> o_mem_addr[11:8] == 4'h0;
  endproperty
  a_bank0: assert property (p_bank0) else $error("stack outside bank 0");

  property p_admit;
    @(posedge i_clk_sys) disable iff (i_rst)
      (level_q == stack_psw_pkg::LEVEL_NONE) |-> !o_irq_admit;
  endproperty
  a_admit: assert property (p_admit) else $error("level 2 admitted");

  property p_reset_clear;
    @(posedge i_clk_sys) $fell(i_rst) |-> carrier_q == 16'h0000 && level_q == 2'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");

  property p_call_frame;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == ST_IDLE && i_cmd_valid && i_cmd == stack_psw_pkg::CMD_CALL)
      |=> o_busy [*7] ##1 o_done;
  endproperty
  a_call_frame: assert property (p_call_frame) else $error("call not six nibbles");

  property p_irq_level;
    @(posedge i_clk_sys) disable iff (i_rst)
      (state_q == ST_RUN && cmd_q == stack_psw_pkg::CMD_IRQ && step_q == last_step
       && level_q == stack_psw_pkg::LEVEL_ALL && !i_reg_wr)
      |=> level_q == stack_psw_pkg::LEVEL_HIGH;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("level not raised");
endmodule : stack_psw_control

// ===== core/stack_psw_pkg.sv
package stack_psw_pkg;
  // data memory nibble addresses
  localparam logic [11:0] ADDR_SP_LO = 12'hf80;
  localparam logic [11:0] ADDR_SP_HI = 12'hf81;
  localparam logic [11:0] ADDR_STATUS_HI = 12'hfb0;
  localparam logic [11:0] ADDR_STATUS_LO = 12'hfb1;
  localparam logic [11:0] ADDR_CARRIER0 = 12'hfc0;
  localparam logic [11:0] ADDR_CARRIER1 = 12'hfc1;
  localparam logic [11:0] ADDR_CARRIER2 = 12'hfc2;
  localparam logic [11:0] ADDR_CARRIER3 = 12'hfc3;
  // status word and vector byte bit positions
  localparam int POS_LEVEL_HI = 3;
  localparam int POS_LEVEL_LO = 2;
  localparam int POS_MEM_BANK = 1;
  localparam int POS_REG_BANK = 0;
  localparam int POS_CARRY = 3;
  localparam int POS_VEC_REG_BANK = 6;
  localparam int POS_VEC_MEM_BANK = 7;
  // reset values
  localparam logic [15:0] RST_CARRIER = 16'h0000;
  localparam logic [1:0] RST_LEVEL = 2'h0;
  localparam logic [2:0] RST_SKIP = 3'h0;
  localparam logic [7:0] RST_SP = 8'h00;
  // stack frame sizes in nibbles
  localparam logic [7:0] FRAME_PAIR = 8'h02;
  localparam logic [7:0] FRAME_CALL = 8'h06;
  // interrupt admission levels
  localparam logic [1:0] LEVEL_ALL = 2'h0;
  localparam logic [1:0] LEVEL_HIGH = 2'h1;
  localparam logic [1:0] LEVEL_NONE = 2'h2;
  // access widths
  localparam logic [1:0] ACC_BIT = 2'h0;
  localparam logic [1:0] ACC_NIB = 2'h1;
  localparam logic [1:0] ACC_BYTE = 2'h2;
  // stack commands from the sequencer
  typedef enum logic [2:0] {
    CMD_NONE, CMD_PUSH, CMD_POP, CMD_CALL, CMD_RET, CMD_IRQ, CMD_INTERRUPT_EXIT
  } stack_cmd_type;
endpackage : stack_psw_pkg

// ===== dv/stack_mem_model.sv
`timescale 1ns/100ps
module stack_mem_model (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [11:0] i_addr,
  input wire logic [3:0] i_wdata,
  output logic [3:0] o_rdata,
  output logic o_bad_addr
);
  logic [3:0] mem_q [256];
  logic [3:0] last_q = 4'h0;
  logic bad_q = 1'b0;
  // an idle read port shows the inverse so a stale nibble never matches
  assign o_rdata = i_re ? mem_q[i_addr[7:0]] : ~last_q;
  assign o_bad_addr = bad_q;
  always @(posedge i_clk_sys) begin
    if (i_we)
      mem_q[i_addr[7:0]] <= i_wdata;
    if (i_re)
      last_q <= mem_q[i_addr[7:0]];
    if ((i_we || i_re) && i_addr[11:8] != 4'h0)
      bad_q <= 1'b1;
  end
endmodule : stack_mem_model

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_cmd_valid, o_busy, o_done, i_pc_advance, i_rom_ref, i_jump, mem_bad;
  logic o_mem_we, o_mem_re, i_reg_wr, i_reg_rd, i_idx_wr, i_idx_wbit, o_idx_rbit;
  logic i_carry_set, i_carry_in, i_skip_load, i_irq_high_prio, o_irq_admit;
  logic o_mem_bank_enable_flag, o_reg_bank_enable_flag, o_carry;
  stack_psw_pkg::stack_cmd_type i_cmd;
  logic [7:0] i_push_data, o_pop_data, i_vector_byte, i_reg_wdata, o_reg_rdata, o_stack_ptr;
  logic [13:0] i_rom_ref_target, i_jump_target, i_vector_addr, o_prog_counter;
  logic [11:0] o_mem_addr, i_reg_addr;
  logic [3:0] o_mem_wdata, i_mem_rdata, i_idx_l;
  logic [2:0] i_skip_in;
  logic [1:0] i_instr_len, i_reg_width, i_reg_bit, o_irq_level;
  logic [15:0] o_bit_seq_carrier;
  int mismatches = 0;
  int checks = 0;
  typedef struct packed {
    logic [1:0] w;
    logic [11:0] a;
    logic [1:0] b;
    logic [7:0] d;
    logic [15:0] bit_seq_carrier;
    logic [7:0] rd;
  } row_type;
  row_type rows [5] = '{
    '{stack_psw_pkg::ACC_BYTE, 12'hfc0, 2'h0, 8'h37, 16'h0037, 8'h37},
    '{stack_psw_pkg::ACC_BYTE, 12'hfc2, 2'h0, 8'h59, 16'h5937, 8'h59},
    '{stack_psw_pkg::ACC_NIB, 12'hfc1, 2'h0, 8'h0c, 16'h59c7, 8'h0c},
    '{stack_psw_pkg::ACC_BIT, 12'hfc3, 2'h2, 8'h00, 16'h19c7, 8'h00},
    '{stack_psw_pkg::ACC_BIT, 12'hfc0, 2'h3, 8'h01, 16'h19cf, 8'h01}};

  always #4 i_clk_sys = ~i_clk_sys;

  stack_psw_control u_dut (.i_clk_sys, .i_rst, .i_cmd_valid, .i_cmd, .i_push_data, .o_busy,
    .o_done, .o_pop_data, .i_pc_advance, .i_instr_len, .i_rom_ref, .i_rom_ref_target, .i_jump,
    .i_jump_target, .i_vector_addr, .i_vector_byte, .o_prog_counter, .o_mem_we, .o_mem_re,
    .o_mem_addr, .o_mem_wdata, .i_mem_rdata, .i_reg_wr, .i_reg_rd, .i_reg_width, .i_reg_addr,
    .i_reg_bit, .i_reg_wdata, .o_reg_rdata, .i_idx_wr, .i_idx_l, .i_idx_wbit, .o_idx_rbit,
    .i_carry_set, .i_carry_in, .i_skip_in, .i_skip_load, .i_irq_high_prio, .o_irq_admit,
    .o_irq_level, .o_mem_bank_enable_flag, .o_reg_bank_enable_flag, .o_carry, .o_stack_ptr,
    .o_bit_seq_carrier);

  stack_mem_model u_mem (.i_clk_sys, .i_we(o_mem_we), .i_re(o_mem_re), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata), .o_bad_addr(mem_bad));

  task automatic end_of_test();
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic run_cmd(input stack_psw_pkg::stack_cmd_type c, input logic [7:0] d);
    int n;
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b1;
    i_cmd = c;
    i_push_data = d;
    @(negedge i_clk_sys);
    // a push held into the busy cycle must be ignored
    i_cmd = stack_psw_pkg::CMD_PUSH;
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    check("done", {15'h0, o_done}, 16'h1);
    repeat (3) @(negedge i_clk_sys);
  endtask : run_cmd

  task automatic reg_acc(input logic wr, input logic [1:0] w, input logic [11:0] a,
      input logic [1:0] b, input logic [7:0] d);
    @(negedge i_clk_sys);
    i_reg_wr = wr;
    i_reg_rd = !wr;
    i_reg_width = w;
    i_reg_addr = a;
    i_reg_bit = b;
    i_reg_wdata = d;
    @(negedge i_clk_sys);
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
  endtask : reg_acc

  task automatic jump_to(input logic [13:0] t);
    @(negedge i_clk_sys);
    i_jump = 1'b1;
    i_jump_target = t;
    @(negedge i_clk_sys);
    i_jump = 1'b0;
  endtask : jump_to

  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end

  initial begin
    {i_cmd_valid, i_pc_advance, i_rom_ref, i_jump, i_reg_wr, i_reg_rd} = 6'h00;
    {i_idx_wr, i_idx_wbit, i_carry_set, i_carry_in, i_skip_load, i_irq_high_prio} = 6'h00;
    i_cmd = stack_psw_pkg::CMD_NONE;
    {i_push_data, i_vector_byte, i_reg_wdata} = 24'h000000;
    {i_rom_ref_target, i_jump_target, i_vector_addr} = 42'h0;
    {i_reg_addr, i_idx_l, i_skip_in} = 19'h00000;
    {i_instr_len, i_reg_width, i_reg_bit} = 6'h00;
    repeat (12) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check("sp", {8'h00, o_stack_ptr}, 16'h0000);
    check("pc", {2'h0, o_prog_counter}, 16'h0000);
    check("carrier", o_bit_seq_carrier, 16'h0000);
    check("level", {14'h0, o_irq_level}, 16'h0000);
    foreach (rows[i]) begin
      reg_acc(1'b1, rows[i].w, rows[i].a, rows[i].b, rows[i].d);
      check("carrier", o_bit_seq_carrier, rows[i].bit_seq_carrier);
      reg_acc(1'b0, rows[i].w, rows[i].a, rows[i].b, 8'h00);
      check("reg_rdata", {8'h00, o_reg_rdata}, {8'h00, rows[i].rd});
    end
    // indexed access with the bank flag set must still land in the carrier
    reg_acc(1'b1, stack_psw_pkg::ACC_BIT, stack_psw_pkg::ADDR_STATUS_HI, 2'h1, 8'h01);
    check("mem_bank", {15'h0, o_mem_bank_enable_flag}, 16'h0001);
    @(negedge i_clk_sys);
    i_idx_wr = 1'b1;
    i_idx_l = 4'hf;
    i_idx_wbit = 1'b1;
    @(negedge i_clk_sys);
    i_idx_wr = 1'b0;
    check("carrier", o_bit_seq_carrier, 16'h99cf);
    i_idx_l = 4'h5;
    #1 check("idx_bit", {15'h0, o_idx_rbit}, 16'h0000);
    reg_acc(1'b1, stack_psw_pkg::ACC_BIT, stack_psw_pkg::ADDR_STATUS_HI, 2'h0, 8'h01);
    run_cmd(stack_psw_pkg::CMD_PUSH, 8'ha5);
    check("sp", {8'h00, o_stack_ptr}, 16'h00fe);
    check("upper", {12'h0, u_mem.mem_q[8'hff]}, 16'h000a);
    check("lower", {12'h0, u_mem.mem_q[8'hfe]}, 16'h0005);
    run_cmd(stack_psw_pkg::CMD_POP, 8'h00);
    check("pop", {8'h00, o_pop_data}, 16'h00a5);
    check("sp", {8'h00, o_stack_ptr}, 16'h0000);
    jump_to(14'h2abc);
    run_cmd(stack_psw_pkg::CMD_CALL, 8'h00);
    check("sp", {8'h00, o_stack_ptr}, 16'h00fa);
    check("frame", {12'h0, u_mem.mem_q[8'hff]}, 16'h000b);
    jump_to(14'h0000);
    // clear both flags so the exit has to bring them back
    reg_acc(1'b1, stack_psw_pkg::ACC_BIT, stack_psw_pkg::ADDR_STATUS_HI, 2'h1, 8'h00);
    reg_acc(1'b1, stack_psw_pkg::ACC_BIT, stack_psw_pkg::ADDR_STATUS_HI, 2'h0, 8'h00);
    check("flags", {14'h0, o_mem_bank_enable_flag, o_reg_bank_enable_flag}, 16'h0);
    run_cmd(stack_psw_pkg::CMD_RET, 8'h00);
    check("pc", {2'h0, o_prog_counter}, 16'h2abc);
    check("flags", {14'h0, o_mem_bank_enable_flag, o_reg_bank_enable_flag}, 16'h3);
    check("sp", {8'h00, o_stack_ptr}, 16'h0000);
    @(negedge i_clk_sys);
    i_carry_set = 1'b1;
    i_carry_in = 1'b1;
    i_vector_addr = 14'h0123;
    i_vector_byte = 8'h40;
    @(negedge i_clk_sys);
    i_carry_set = 1'b0;
    run_cmd(stack_psw_pkg::CMD_IRQ, 8'h00);
    check("pc", {2'h0, o_prog_counter}, 16'h0123);
    check("flags", {14'h0, o_mem_bank_enable_flag, o_reg_bank_enable_flag}, 16'h1);
    check("level", {14'h0, o_irq_level}, 16'h0001);
    check("sp", {8'h00, o_stack_ptr}, 16'h00fa);
    reg_acc(1'b1, stack_psw_pkg::ACC_BIT, stack_psw_pkg::ADDR_STATUS_LO, 2'h3, 8'h00);
    run_cmd(stack_psw_pkg::CMD_INTERRUPT_EXIT, 8'h00);
    check("pc", {2'h0, o_prog_counter}, 16'h2abc);
    check("status", {12'h0, o_irq_level, o_mem_bank_enable_flag, o_reg_bank_enable_flag},
      16'h0003);
    check("carry", {15'h0, o_carry}, 16'h0001);
    check("sp", {8'h00, o_stack_ptr}, 16'h0000);
    for (int lvl = 0; lvl < 3; lvl++) begin
      // level written directly only while no interrupt entry is in flight
      reg_acc(1'b1, stack_psw_pkg::ACC_NIB, stack_psw_pkg::ADDR_STATUS_HI, 2'h0,
        {4'h0, lvl[1:0], 2'h3});
      for (int p = 0; p < 2; p++) begin
        @(negedge i_clk_sys);
        i_irq_high_prio = p[0];
        #1 check("admit", {15'h0, o_irq_admit}, {15'h0, lvl == 0 || (lvl == 1 && p == 1)});
      end
    end
    @(negedge i_clk_sys);
    i_skip_load = 1'b1;
    i_skip_in = 3'h5;
    @(negedge i_clk_sys);
    i_skip_load = 1'b0;
    reg_acc(1'b1, stack_psw_pkg::ACC_BIT, stack_psw_pkg::ADDR_STATUS_LO, 2'h3, 8'h00);
    reg_acc(1'b1, stack_psw_pkg::ACC_NIB, stack_psw_pkg::ADDR_STATUS_LO, 2'h0, 8'h00);
    reg_acc(1'b0, stack_psw_pkg::ACC_BYTE, stack_psw_pkg::ADDR_STATUS_HI, 2'h0, 8'h00);
    check("status_byte", {8'h00, o_reg_rdata}, 16'h005b);
    jump_to(14'h0100);
    @(negedge i_clk_sys);
    i_pc_advance = 1'b1;
    i_instr_len = 2'h2;
    @(negedge i_clk_sys);
    check("pc", {2'h0, o_prog_counter}, 16'h0102);
    i_rom_ref = 1'b1;
    i_rom_ref_target = 14'h0040;
    @(negedge i_clk_sys);
    {i_pc_advance, i_rom_ref} = 2'h0;
    check("pc", {2'h0, o_prog_counter}, 16'h0040);
    reg_acc(1'b1, stack_psw_pkg::ACC_BYTE, stack_psw_pkg::ADDR_SP_LO, 2'h0, 8'h37);
    check("sp", {8'h00, o_stack_ptr}, 16'h0036);
    // second reset in mid-run: carrier and status bits except carry must clear again
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check("carrier", o_bit_seq_carrier, 16'h0000);
    reg_acc(1'b0, stack_psw_pkg::ACC_BYTE, stack_psw_pkg::ADDR_STATUS_HI, 2'h0, 8'h00);
    check("status_byte", {9'h000, o_reg_rdata[6:0]}, 16'h0000);
    check("stack_bank", {15'h0, mem_bad}, 16'h0000);
    end_of_test();
  end
endmodule : tb
